// ### include/pdw_pkg.sv
// pdw_pkg: shared constants and types for the power-down / watchdog block.
// assumes a 100 MHz pclk and a 32-bit APB register port.
package pdw_pkg;

  // register byte addresses
  localparam logic [11:0] PDW_ADDR_WDT_CTRL   = 12'h000;
  localparam logic [11:0] PDW_ADDR_RST_FLAGS  = 12'h004;
  localparam logic [11:0] PDW_ADDR_CLK_CTRL   = 12'h008;
  localparam logic [11:0] PDW_ADDR_WAKE_EN    = 12'h00c;
  localparam logic [11:0] PDW_ADDR_STATUS     = 12'h010;

  // reset value and watchdog keys
  localparam logic [7:0]  PDW_WDT_CTRL_RST    = 8'h52;
  localparam logic [4:0]  PDW_KEY_DISABLE     = 5'h15;
  localparam logic [4:0]  PDW_KEY_ENABLE      = 5'h0a;

  // field positions
  localparam int          PDW_KEY_LSB         = 3;
  localparam int          PDW_WRF_BIT         = 0;
  localparam int          PDW_KEEP_SLOW_BIT   = 0;
  localparam int          PDW_KEEP_FAST_BIT   = 1;

  localparam int          PDW_PORTA_W         = 8;
  localparam int          PDW_WDT_W           = 19;
  localparam int          PDW_SLOW_DIV        = 8;

  // soft reset delay: value in ns and derived pclk cycles
  localparam int          PDW_CLK_NS          = 10;
  localparam int          PDW_SRESET_NS       = 1000;
  localparam int          PDW_SRESET_CYC      = (PDW_SRESET_NS + PDW_CLK_NS - 1) / PDW_CLK_NS;
  localparam logic [7:0]  PDW_SRESET_CNT      = 8'(PDW_SRESET_CYC);

  typedef enum logic [2:0] {
    PDW_RUN, PDW_SLEEP, PDW_IDLE_SLOW, PDW_IDLE_BOTH, PDW_IDLE_FAST
  } pdw_mode_t;

  // timeout exponent for each period code
  function automatic logic [4:0] pdw_period_exp(input logic [2:0] sel);
    unique case (sel)
      3'h0: pdw_period_exp = 5'h08;
      3'h1: pdw_period_exp = 5'h0a;
      3'h2: pdw_period_exp = 5'h0c;
      3'h3: pdw_period_exp = 5'h0e;
      3'h4: pdw_period_exp = 5'h0f;
      3'h5: pdw_period_exp = 5'h10;
      3'h6: pdw_period_exp = 5'h11;
      3'h7: pdw_period_exp = 5'h12;
    endcase
  endfunction

endpackage

// ### core/pdw_tick_div.sv
// pdw_tick_div: divides slow oscillator enable pulses by a fixed ratio.
// assumes slow_tick is a one-cycle enable pulse on pclk.
`timescale 1ns/1ps
`default_nettype none
module pdw_tick_div (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic slow_tick,
  input  wire logic run,
  output logic      tick
);
  import pdw_pkg::*;

  typedef struct packed {
    logic [2:0] cnt;
  } pdw_div_t;

  pdw_div_t st_r, st_nxt;

  // wrap every eighth slow pulse
  always_comb begin
    st_nxt = st_r;
    if (run && slow_tick) begin
      st_nxt.cnt = st_r.cnt + 3'h1;
    end
  end

  assign tick = run && slow_tick && (st_r.cnt == 3'(PDW_SLOW_DIV - 1)); // [R15]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule
`default_nettype wire

// ### core/pdw_edge_det.sv
// pdw_edge_det: falling-edge detection on port-a pins gated by wake enables.
// assumes port pins are synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module pdw_edge_det (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [7:0] pins,
  input  wire logic [7:0] enable,
  output logic            wake
);
  import pdw_pkg::*;

  typedef struct packed {
    logic [7:0] prev;
  } pdw_edge_t;

  pdw_edge_t st_r, st_nxt;
  logic [7:0] fall;

  // one detector per pin
  genvar g;
  generate
    for (g = 0; g < PDW_PORTA_W; g++) begin : g_pin
      assign fall[g] = st_r.prev[g] && !pins[g] && enable[g]; // [R11]
    end
  endgenerate

  always_comb begin
    st_nxt      = st_r;
    st_nxt.prev = pins;
  end

  assign wake = |fall;

  // idle pins sit high, so reset to ones avoids a false edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule
`default_nettype wire

// ### core/pdw_core.sv
// pdw_core: power-down controller and watchdog with an apb register port.
// assumes the cpu pulses halt/clr instructions and the slow oscillator as enables.
//
// Contract
// [R01] deepest sleep stops system clock, holds at halt, state preserved.
// [R02] fast keep 0, slow keep 1: fast clock off, slow on.
// [R03] both keep bits 1: both clocks run, program stopped.
// [R04] fast keep 1, slow keep 0: fast on, slow off.
// [R05] halt sets power-down flag and clears timeout flag.
// [R06] halt clears watchdog counter; it counts on only if enabled.
// [R07] wake on port-a fall, external reset, interrupt or watchdog overflow.
// [R08] external reset wake does a full reset.
// [R09] power-down flag clears only on power-up or watchdog clear.
// [R10] overflow in standby sets timeout, resets only pc and stack.
// [R11] per-pin wake enable; enabled falling edge wakes after halt.
// [R12] disabled or stack-full interrupt wakes after halt, stays pending.
// [R13] enabled interrupt with stack room takes normal interrupt entry.
// [R14] interrupt already pending at halt cannot wake the device.
// [R15] watchdog tick is the slow crystal divided by eight.
// [R16] period code selects two to the 8..18 ticks.
// [R17] key 10101 disables, 01010 enables, other values reset.
// [R18] illegal key resets after fixed delay and sets soft-reset flag.
// [R19] soft-reset flag at bit 0 set by hardware, cleared by writing zero.
// [R20] both keep bits 0: everything off except the watchdog.
// [R21] timeout in run mode resets the device and sets timeout flag.
// [R22] software restarts the watchdog only with the clear instruction.
// [R23] keep bits sampled at halt alone choose the standby state.
// [R24] port-a wake edges detected on the running clock.
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module pdw_core (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [11:0]                paddr,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic                            pready,
  output logic [31:0]                     prdata,
  output logic                            pslverr,
  input  wire logic                       halt_exec,
  input  wire logic                       wdt_clear_exec,
  input  wire logic                       slow_osc_tick,
  input  wire logic                       ext_reset_req,
  input  wire logic [pdw_pkg::PDW_PORTA_W-1:0] porta_pins,
  input  wire logic                       irq_req,
  input  wire logic                       irq_enabled,
  input  wire logic                       stack_full,
  output logic                            sys_clk_en,
  output logic                            fast_clk_en,
  output logic                            slow_clk_en,
  output logic                            cpu_halted,
  output logic                            resume_next,
  output logic                            irq_entry,
  output logic                            pc_sp_reset,
  output logic                            device_reset
);
  import pdw_pkg::*;

  typedef struct packed {
    pdw_mode_t                mode;
    logic [7:0]               wdt_ctrl;
    logic [1:0]               keep;
    logic [PDW_PORTA_W-1:0]   wake_en;
    logic                     powerdown_flag;
    logic                     wdt_expiry_flag;
    logic                     wdt_ctrl_soft_reset_flag;
    logic [PDW_WDT_W-1:0]     wdt_cnt;
    logic                     irq_armed;
    logic                     sreset_busy;
    logic [7:0]               sreset_cnt;
    logic [31:0]              rdata;
    logic                     resume;
    logic                     irq_go;
    logic                     pcsp;
    logic                     dev_rst;
  } pdw_state_t;

  pdw_state_t st_r, st_nxt;
  logic       wdt_tick;
  logic       porta_wake;
  logic       wr_acc;
  logic       rd_acc;
  logic [4:0] key;
  logic       wdt_on;
  logic       key_bad;
  logic       overflow;
  logic       standby;
  logic       irq_wake;
  logic       wake;

  // decode an apb register address to a hit
  function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
    hit = (a == b);
  endfunction

  assign key      = st_r.wdt_ctrl[PDW_KEY_LSB +: 5];
  assign wdt_on   = (key == PDW_KEY_ENABLE);                              // [R17]
  assign key_bad  = !wdt_on && (key != PDW_KEY_DISABLE);                  // [R17]
  assign overflow = wdt_on && st_r.wdt_cnt[pdw_period_exp(st_r.wdt_ctrl[2:0])]; // [R16]
  assign standby  = (st_r.mode != PDW_RUN);
  assign wr_acc   = psel && penable && pwrite;
  assign rd_acc   = psel && !penable && !pwrite;
  // a request latched before halt is disarmed and cannot wake
  assign irq_wake = irq_req && st_r.irq_armed;                            // [R14]
  assign wake     = standby && (porta_wake || irq_wake || overflow);      // [R07]

  // watchdog ticks follow the slow crystal; the divider halts only in idle-fast while the watchdog is disabled
  pdw_tick_div u_div (
    .pclk      (pclk),
    .presetn   (presetn),
    .slow_tick (slow_osc_tick),
    .run       (st_r.mode != PDW_IDLE_FAST || wdt_on),
    .tick      (wdt_tick)
  );

  // edge detection runs on pclk, which stays alive for this block in every mode
  pdw_edge_det u_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .pins    (porta_pins),
    .enable  (st_r.wake_en),
    .wake    (porta_wake)                                                 // [R24]
  );

  // next-state logic: modes, flags, watchdog and register writes
  always_comb begin
    st_nxt         = st_r;
    st_nxt.resume  = 1'b0;
    st_nxt.irq_go  = 1'b0;
    st_nxt.pcsp    = 1'b0;
    st_nxt.dev_rst = 1'b0;
    if (!irq_req) begin
      st_nxt.irq_armed = 1'b1;
    end
    // watchdog counting; counter stays cleared while disabled
    if (!wdt_on) begin
      st_nxt.wdt_cnt = '0;                                                // [R06]
    end else if (wdt_tick) begin
      st_nxt.wdt_cnt = st_r.wdt_cnt + 19'h1;
    end
    if (wdt_clear_exec) begin
      st_nxt.wdt_cnt        = '0;                                         // [R22]
      st_nxt.powerdown_flag = 1'b0;                                       // [R09]
    end
    if (overflow) begin
      st_nxt.wdt_cnt         = '0;
      st_nxt.wdt_expiry_flag = 1'b1;                                      // [R10] [R21]
      if (standby) begin
        st_nxt.pcsp = 1'b1;                                               // [R10]
      end else begin
        st_nxt.dev_rst = 1'b1;                                            // [R21]
      end
    end
    // halt: mode picked only from the keep bits sampled now
    if (!standby && halt_exec) begin
      unique case (st_r.keep)                                             // [R23]
        2'b00:   st_nxt.mode = PDW_SLEEP;                                 // [R01] [R20]
        2'b01:   st_nxt.mode = PDW_IDLE_SLOW;                             // [R02]
        2'b11:   st_nxt.mode = PDW_IDLE_BOTH;                             // [R03]
        2'b10:   st_nxt.mode = PDW_IDLE_FAST;                             // [R04]
      endcase
      st_nxt.powerdown_flag  = 1'b1;                                      // [R05]
      st_nxt.wdt_expiry_flag = 1'b0;                                      // [R05]
      st_nxt.wdt_cnt         = '0;                                        // [R06]
      st_nxt.irq_armed       = !irq_req;                                  // [R14]
    end
    if (wake) begin
      st_nxt.mode = PDW_RUN;
      if (irq_wake && !porta_wake && !overflow && irq_enabled && !stack_full) begin
        st_nxt.irq_go = 1'b1;                                             // [R13]
      end else if (!overflow) begin
        st_nxt.resume = 1'b1;                                             // [R11] [R12]
      end
    end
    // illegal key: count the fixed delay, then reset and flag
    if (key_bad && !st_r.sreset_busy) begin
      st_nxt.sreset_busy = 1'b1;
      st_nxt.sreset_cnt  = PDW_SRESET_CNT;
    end else if (st_r.sreset_busy) begin
      if (st_r.sreset_cnt == 8'h01) begin
        st_nxt.sreset_busy = 1'b0;
        st_nxt.dev_rst     = 1'b1;                                        // [R18]
        st_nxt.wdt_ctrl_soft_reset_flag         = 1'b1;                                        // [R18]
        st_nxt.wdt_ctrl    = PDW_WDT_CTRL_RST;
        st_nxt.mode        = PDW_RUN;
      end else begin
        st_nxt.sreset_cnt = st_r.sreset_cnt - 8'h01;
      end
    end
    // apb writes; the soft-reset flag only accepts a zero, and a set the same cycle wins only while the flag is clear
    if (wr_acc && pstrb[0]) begin
      if (hit(paddr, PDW_ADDR_WDT_CTRL)) begin
        st_nxt.wdt_ctrl = pwdata[7:0];
      end
      if (hit(paddr, PDW_ADDR_RST_FLAGS) && !pwdata[PDW_WRF_BIT] && st_nxt.wdt_ctrl_soft_reset_flag == st_r.wdt_ctrl_soft_reset_flag) begin
        st_nxt.wdt_ctrl_soft_reset_flag = 1'b0;                                                // [R19]
      end
      if (hit(paddr, PDW_ADDR_CLK_CTRL)) begin
        st_nxt.keep = pwdata[1:0];
      end
      if (hit(paddr, PDW_ADDR_WAKE_EN)) begin
        st_nxt.wake_en = pwdata[PDW_PORTA_W-1:0];
      end
    end
    // external reset: resets mode, watchdog control, count, timeout flag and key delay; keeps keep bits, wake enables, power-down and soft-reset flags
    if (ext_reset_req) begin
      st_nxt.mode            = PDW_RUN;                                   // [R08]
      st_nxt.wdt_ctrl        = PDW_WDT_CTRL_RST;
      st_nxt.wdt_cnt         = '0;
      st_nxt.wdt_expiry_flag = 1'b0;
      st_nxt.sreset_busy     = 1'b0;
      st_nxt.dev_rst         = 1'b1;                                      // [R08]
    end
    // read data registered in the setup phase
    if (rd_acc) begin
      unique case (paddr)
        PDW_ADDR_WDT_CTRL:  st_nxt.rdata = {24'h0, st_r.wdt_ctrl};
        PDW_ADDR_RST_FLAGS: st_nxt.rdata = {31'h0, st_r.wdt_ctrl_soft_reset_flag};
        PDW_ADDR_CLK_CTRL:  st_nxt.rdata = {30'h0, st_r.keep};
        PDW_ADDR_WAKE_EN:   st_nxt.rdata = {24'h0, st_r.wake_en};
        PDW_ADDR_STATUS:    st_nxt.rdata = {26'h0, st_r.mode, st_r.wdt_expiry_flag, st_r.powerdown_flag, wdt_on};
        default:            st_nxt.rdata = 32'h0;
      endcase
    end
  end

  // state register; status word is mode, timeout flag, power-down flag, watchdog enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r          <= '0;
      st_r.mode     <= PDW_RUN;
      st_r.wdt_ctrl <= PDW_WDT_CTRL_RST;
      st_r.irq_armed <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pready       = 1'b1;
  assign pslverr      = 1'b0;
  assign prdata       = st_r.rdata;
  assign sys_clk_en   = !standby;                                         // [R01]
  assign fast_clk_en  = (st_r.mode == PDW_RUN) || (st_r.mode == PDW_IDLE_BOTH) || (st_r.mode == PDW_IDLE_FAST);
  assign slow_clk_en  = (st_r.mode == PDW_RUN) || (st_r.mode == PDW_IDLE_BOTH) || (st_r.mode == PDW_IDLE_SLOW);
  assign cpu_halted   = standby;
  assign resume_next  = st_r.resume;
  assign irq_entry    = st_r.irq_go;
  assign pc_sp_reset  = st_r.pcsp;
  assign device_reset = st_r.dev_rst;

  // halt moves into a standby mode on the next edge with flags updated
  halt_entry_a: assert property (@(posedge pclk) disable iff (!presetn) // [R05]
    (!standby && halt_exec && !ext_reset_req && !(st_r.sreset_busy && st_r.sreset_cnt == 8'h01))
    |=> (st_r.mode != PDW_RUN) && st_r.powerdown_flag && !st_r.wdt_expiry_flag)
    else $error("halt did not enter standby with flags");

  keep_sleep_a: assert property (@(posedge pclk) disable iff (!presetn) // [R20]
    (!standby && halt_exec && st_r.keep == 2'b00 && !ext_reset_req && !key_bad && !st_r.sreset_busy)
    |=> !fast_clk_en && !slow_clk_en && !sys_clk_en)
    else $error("sleep left a clock running");

  // slow-only idle: the fast clock stops
  keep_slow_a: assert property (@(posedge pclk) disable iff (!presetn) // [R02]
    (!standby && halt_exec && st_r.keep == 2'b01 && !ext_reset_req && !st_r.sreset_busy)
    |=> !fast_clk_en && slow_clk_en && cpu_halted)
    else $error("slow-only idle entered wrongly");

  // both-clock idle: only the cpu stops
  keep_both_a: assert property (@(posedge pclk) disable iff (!presetn) // [R03]
    (!standby && halt_exec && st_r.keep == 2'b11 && !ext_reset_req && !st_r.sreset_busy)
    |=> fast_clk_en && slow_clk_en && cpu_halted)
    else $error("both-clock idle entered wrongly");

  // fast-only idle: the slow clock stops
  keep_fast_a: assert property (@(posedge pclk) disable iff (!presetn) // [R04]
    (!standby && halt_exec && st_r.keep == 2'b10 && !ext_reset_req && !st_r.sreset_busy)
    |=> fast_clk_en && !slow_clk_en && cpu_halted)
    else $error("fast-only idle entered wrongly");

  // halt restarts the count from zero
  halt_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // [R06]
    (!standby && halt_exec) |=> st_r.wdt_cnt == '0)
    else $error("halt left the watchdog count");

  // a disabled watchdog stays parked at zero
  wdt_stop_a: assert property (@(posedge pclk) disable iff (!presetn) // [R06]
    !wdt_on |=> st_r.wdt_cnt == '0)
    else $error("disabled watchdog kept counting");

  // a tick takes eight slow pulses, so seven quiet cycles follow it
  div_ratio_a: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
    wdt_tick |=> !wdt_tick [*7])
    else $error("watchdog tick faster than the divider");

  pd_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // [R09]
    $fell(st_r.powerdown_flag) |-> $past(wdt_clear_exec))
    else $error("power-down flag cleared without clear instruction");

  wrf_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // [R19]
    $fell(st_r.wdt_ctrl_soft_reset_flag) |-> $past(wr_acc) && $past(paddr) == PDW_ADDR_RST_FLAGS)
    else $error("soft-reset flag cleared by hardware");

  run_timeout_a: assert property (@(posedge pclk) disable iff (!presetn) // [R21]
    (overflow && !standby && !ext_reset_req) |=> device_reset && st_r.wdt_expiry_flag)
    else $error("run-mode timeout did not reset");

  sleep_timeout_a: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
    (overflow && standby && !ext_reset_req) |=> pc_sp_reset && !device_reset ##1 !pc_sp_reset)
    else $error("standby timeout not a pc/sp reset");

  bad_key_a: assert property (@(posedge pclk) disable iff (!presetn) // [R18]
    (key_bad && !st_r.sreset_busy && !ext_reset_req) |=> st_r.sreset_busy ##[1:120] st_r.wdt_ctrl_soft_reset_flag)
    else $error("illegal key did not set soft-reset flag");

  stale_irq_a: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
    (!standby && halt_exec && irq_req) |=> !st_r.irq_armed)
    else $error("stale interrupt still able to wake");

  // external reset wakes with a full reset pulse
  ext_wake_a: assert property (@(posedge pclk) disable iff (!presetn) // [R07] [R08]
    (standby && ext_reset_req) |=> !cpu_halted && device_reset)
    else $error("external reset did not wake with a reset");

  // pin wake resumes after the halt
  pin_wake_a: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
    (standby && porta_wake && !overflow) |=> !cpu_halted && resume_next && !irq_entry)
    else $error("port-a wake did not resume after halt");

  // a serviceable interrupt takes the entry sequence
  irq_take_a: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
    (standby && irq_wake && !porta_wake && !overflow && irq_enabled && !stack_full)
    |=> irq_entry && !resume_next && !cpu_halted)
    else $error("interrupt wake skipped interrupt entry");

  // a blocked interrupt only resumes, leaving it pending
  irq_resume_a: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
    (standby && irq_wake && !porta_wake && !overflow && (!irq_enabled || stack_full))
    |=> resume_next && !irq_entry && !cpu_halted)
    else $error("blocked interrupt wake did not resume");

endmodule
`default_nettype wire

// ### bench/tb_top.sv
// tb_top: self-checking bench for the power-down / watchdog block.
// assumes pdw_pkg is compiled first; drives apb and cpu events itself.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pdw_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd_v;
  logic [3:0]  pstrb = 4'hf;
  logic        pready, pslverr, halt_exec = 1'b0, wdt_clear_exec = 1'b0, slow_osc_tick = 1'b0;
  logic        ext_reset_req = 1'b0, irq_req = 1'b0, irq_enabled = 1'b0, stack_full = 1'b0;
  logic [7:0]  porta_pins = 8'hff;
  logic        sys_clk_en, fast_clk_en, slow_clk_en, cpu_halted;
  logic        resume_next, irq_entry, pc_sp_reset, device_reset;
  int          n_errors = 0, tests_run = 0, n_rst = 0, n, r0;
  logic [1:0]  irq_cfg [3] = '{2'b10, 2'b11, 2'b00};
  int          irq_exp [3] = '{1, 0, 0};
  pdw_mode_t   mexp [4] = '{PDW_SLEEP, PDW_IDLE_SLOW, PDW_IDLE_FAST, PDW_IDLE_BOTH};

  pdw_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .halt_exec(halt_exec), .wdt_clear_exec(wdt_clear_exec), .slow_osc_tick(slow_osc_tick),
    .ext_reset_req(ext_reset_req), .porta_pins(porta_pins), .irq_req(irq_req),
    .irq_enabled(irq_enabled), .stack_full(stack_full), .sys_clk_en(sys_clk_en),
    .fast_clk_en(fast_clk_en), .slow_clk_en(slow_clk_en), .cpu_halted(cpu_halted),
    .resume_next(resume_next), .irq_entry(irq_entry), .pc_sp_reset(pc_sp_reset),
    .device_reset(device_reset));

  // free-running 100 MHz clock
  always #5 pclk = ~pclk;

  // count reset pulses so a scenario can tell whether one slipped out
  always @(posedge pclk) if (device_reset === 1'b1) n_rst++;

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one apb transfer; starts a cycle after the caller so no signal is assigned twice per step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    apb(1'b1, a, d, dummy);
  endtask

  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] v;
    apb(1'b0, a, 32'h0, v);
    check(nm, exp, v);
  endtask

  task automatic pulse_halt;
    @(posedge pclk) halt_exec <= 1'b1;
    @(posedge pclk) halt_exec <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  task automatic pulse_clear;
    @(posedge pclk) wdt_clear_exec <= 1'b1;
    @(posedge pclk) wdt_clear_exec <= 1'b0;
  endtask

  function automatic logic outsel(input int k);
    case (k)
      0: return resume_next;
      1: return irq_entry;
      2: return pc_sp_reset;
      default: return device_reset;
    endcase
  endfunction

  // bounded wait for a one-cycle pulse; n equals lim if it never came
  task automatic wait_out(input int k, input int lim, output int cnt);
    cnt = 0;
    do begin
      @(posedge pclk);
      cnt++;
    end while (outsel(k) !== 1'b1 && cnt < lim);
  endtask

  task automatic clk_chk(input string nm, input logic [3:0] exp);
    check(nm, {28'h0, exp}, {28'h0, cpu_halted, sys_clk_en, fast_clk_en, slow_clk_en});
  endtask

  // hang guard: the whole run needs under 100 us
  initial begin
    #500us;
    n_errors++;
    finish_test();
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("ctrl reset", PDW_ADDR_WDT_CTRL, 32'h52);
    rd_chk("flags reset", PDW_ADDR_RST_FLAGS, 32'h0);
    rd_chk("unmapped", 12'h020, 32'h0);
    rd_chk("status reset", PDW_ADDR_STATUS, 32'h1);
    clk_chk("run clocks", 4'b0111);
    $display("test reset done");

    // every keep-bit code, a late keep write, a masked pin, then a port-a wake
    for (int k = 0; k < 4; k++) begin
      wr(PDW_ADDR_CLK_CTRL, 32'(k));
      pulse_halt();
      clk_chk("standby clocks", {2'b10, 2'(k)});
      rd_chk("standby status", PDW_ADDR_STATUS, {26'h0, 3'(mexp[k]), 3'b011});
      wr(PDW_ADDR_CLK_CTRL, 32'(~k & 3));
      clk_chk("keep sampled at halt", {2'b10, 2'(k)});
      wr(PDW_ADDR_WAKE_EN, 32'h01);
      @(posedge pclk) porta_pins <= 8'hfd;
      repeat (5) @(posedge pclk);
      check("masked pin", 32'h1, {31'h0, cpu_halted});
      porta_pins <= 8'hff;
      repeat (2) @(posedge pclk);
      porta_pins <= 8'hfe;
      wait_out(0, 10, n);
      check("pin wake", 32'h1, {31'h0, n < 10});
      porta_pins <= 8'hff;
      repeat (2) @(posedge pclk);
      clk_chk("after wake", 4'b0111);
    end
    $display("test modes done");

    // interrupt wake: enabled with room, stack full, disabled
    for (int c = 0; c < 3; c++) begin
      irq_enabled <= irq_cfg[c][1];
      stack_full  <= irq_cfg[c][0];
      pulse_halt();
      irq_req <= 1'b1;
      wait_out(irq_exp[c], 10, n);
      check("irq wake", 32'h1, {31'h0, n < 10});
      irq_req <= 1'b0;
      repeat (2) @(posedge pclk);
    end
    irq_req <= 1'b1;
    pulse_halt();
    repeat (10) @(posedge pclk);
    check("pending irq no wake", 32'h1, {31'h0, cpu_halted});
    irq_req <= 1'b0;
    @(posedge pclk) irq_req <= 1'b1;
    wait_out(0, 10, n);
    check("rearmed irq wake", 32'h1, {31'h0, n < 10});
    irq_req <= 1'b0;
    $display("test irq done");

    // shortest period in run mode: 2^8 ticks of eight slow cycles each
    slow_osc_tick <= 1'b1;
    wr(PDW_ADDR_WDT_CTRL, 32'h50);
    pulse_clear();
    wait_out(3, 2200, n);
    check("run timeout", 32'h1, {31'h0, n >= 2040 && n <= 2080});
    rd_chk("run timeout flag", PDW_ADDR_STATUS, 32'h5);
    // halt part way clears the count; standby overflow only resets pc and stack
    wr(PDW_ADDR_WDT_CTRL, 32'h50);
    wr(PDW_ADDR_CLK_CTRL, 32'h3);
    pulse_clear();
    repeat (1200) @(posedge pclk);
    r0 = n_rst;
    pulse_halt();
    wait_out(2, 2200, n);
    check("standby timeout", 32'h1, {31'h0, n >= 2030 && n <= 2080});
    check("no device reset", 32'(r0), 32'(n_rst));
    repeat (2) @(posedge pclk);
    clk_chk("after overflow", 4'b0111);
    rd_chk("overflow flags", PDW_ADDR_STATUS, {26'h0, 3'(PDW_RUN), 3'b111});
    pulse_clear();
    rd_chk("clear flags", PDW_ADDR_STATUS, {26'h0, 3'(PDW_RUN), 3'b101});
    wr(PDW_ADDR_WDT_CTRL, 32'ha8);
    r0 = n_rst;
    repeat (2600) @(posedge pclk);
    check("disabled wdt", 32'(r0), 32'(n_rst));
    slow_osc_tick <= 1'b0;
    $display("test watchdog done");

    // illegal key: delayed reset, sticky flag cleared only by a zero write
    wr(PDW_ADDR_WDT_CTRL, 32'h00);
    wait_out(3, 200, n);
    check("bad key delay", 32'h1, {31'h0, n >= 95 && n <= 110});
    rd_chk("flag set", PDW_ADDR_RST_FLAGS, 32'h1);
    rd_chk("ctrl restored", PDW_ADDR_WDT_CTRL, 32'h52);
    wr(PDW_ADDR_RST_FLAGS, 32'h1);
    rd_chk("flag one write", PDW_ADDR_RST_FLAGS, 32'h1);
    wr(PDW_ADDR_RST_FLAGS, 32'h0);
    rd_chk("flag cleared", PDW_ADDR_RST_FLAGS, 32'h0);
    $display("test key done");

    // external reset pin wakes from standby
    r0 = n_rst;
    pulse_halt();
    @(posedge pclk) ext_reset_req <= 1'b1;
    @(posedge pclk) ext_reset_req <= 1'b0;
    repeat (10) @(posedge pclk);
    clk_chk("ext reset wake", 4'b0111);
    check("ext reset pulse", 32'(r0 + 1), 32'(n_rst));
    $display("test ext reset done");
    finish_test();
  end
endmodule
`default_nettype wire
